// ### core/fsq_regs.svh
`ifndef FSQ_REGS_SVH
`define FSQ_REGS_SVH

`define FSQ_CHARS 12
`define FSQ_CHAR_BITS 7
`define FSQ_INSTR_CHARS 6
`define FSQ_SLOTS 10
`define FSQ_CHANNELS 100
`define FSQ_LAST_CHAR 4'hb
`define FSQ_LAST_SLOT 4'h9
`define FSQ_XS3_BIAS 4'h3
`define FSQ_DIGIT_TEN 4'ha
`define FSQ_ZERO_NUMERIC 4'h3
`define FSQ_ZERO_ZONE 2'h0
`define FSQ_CHAN_DIGIT_HI 3
`define FSQ_CHAN_DIGIT_LO 4
`define FSQ_TS_DIGIT 5
`define FSQ_RIGHT_BASE 6
`define FSQ_CHAN_WEIGHT 7'h0a

`endif

// ### core/fsq_pkg.sv
`include "fsq_regs.svh"

package fsq_pkg;

	typedef struct packed {
		logic check;
		logic [1:0] zone;
		logic [3:0] numeric;
	} fsq_char_t;

	typedef enum logic [1:0] {
		FSQ_ST_ADDR = 2'b00,
		FSQ_ST_FETCH = 2'b01,
		FSQ_ST_LEFT = 2'b10,
		FSQ_ST_RIGHT = 2'b11
	} fsq_stage_t;

	typedef struct packed {
		fsq_stage_t stage;
		logic wait_period_flag;
		logic slot_match_flag;
		logic parity_error;
		logic halted;
	} fsq_status_t;

endpackage : fsq_pkg

// ### core/fsq_fetch_sequencer.sv
`timescale 1ns/100ps
`include "fsq_regs.svh"

// Overview of operation
// [RULE_01] A word is twelve seven-bit characters, numbered 1 to 12 from the left.
// [RULE_02] Numeric words carry the sign in character 1; the value is a fraction.
// [RULE_03] Main storage is 100 channels of 10 words, slots numbered 0 to 9.
// [RULE_04] Words move character 12 first; numeric, zone, then check bit within each.
// [RULE_05] The same word slot reaches every channel output in the same minor cycle.
// [RULE_06] The word slot counter advances once per minor cycle, modulo ten.
// [RULE_07] A two-bit stage counter steps 00, 01, 10, 11 in fixed order.
// [RULE_08] Every stage opens with one wait minor cycle; a timing pulse then ends it.
// [RULE_09] Stage one puts the instruction counter on the bus into the pair register.
// [RULE_10] A character with an even count of ones stops the machine at next wait.
// [RULE_11] Stage one end latches characters 7-12, steps the stage and sets wait.
// [RULE_12] The fetch word address comes from counter characters 10 to 12.
// [RULE_13] In stage two the slot counter is compared with the rightmost static character.
// [RULE_14] Characters 4 and 5 select one channel, opened only on a slot match.
// [RULE_15] The slot match may come as late as the eleventh minor cycle of stage two.
// [RULE_16] On the match cycle the word enters the pair register and the counter adds one.
// [RULE_17] The counter captures its whole incremented sum before its input closes.
// [RULE_18] Stage two end latches characters 1-6 while the pair stays held.
// [RULE_19] Each word holds two six-character instructions for stages three and four.
// [RULE_20] In stage three wait the instruction drives decode; afterwards it executes.
// [RULE_21] Stage three end latches the right instruction; stage four end returns to one.
// [RULE_22] Each check bit makes the count of ones in its character odd.
// [RULE_23] After reset the stage counter is in stage one with the wait flag set.

module fsq_fetch_sequencer #(
	parameter int CHARS = `FSQ_CHARS,
	parameter int SLOTS = `FSQ_SLOTS
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire fsq_pkg::fsq_char_t memory_out_bus,
	input wire logic exec_done,
	output logic mem_out_en,
	output logic [6:0] mem_chan_sel,
	output logic [3:0] word_slot_counter,
	output logic [3:0] char_index,
	output logic minor_end,
	output fsq_pkg::fsq_char_t main_bus_two,
	output logic main_bus_valid,
	output logic instr_execute,
	output logic [`FSQ_INSTR_CHARS*`FSQ_CHAR_BITS-1:0] decode_table_signals,
	output fsq_pkg::fsq_status_t status
);
	import fsq_pkg::*;

	// ==========================================================
	// Character helpers
	// ==========================================================

	// Decimal value of an excess-three character.
	function automatic logic [3:0] digit_val(input fsq_char_t c);
		digit_val = c.numeric - `FSQ_XS3_BIAS;
	endfunction : digit_val

	// Builds a character whose check bit gives an odd count of ones.
	function automatic fsq_char_t make_char(input logic [3:0] num, input logic [1:0] zone);
		fsq_char_t c;
		c.numeric = num;
		c.zone = zone;
		c.check = ~^{zone, num}; // RULE_22
		make_char = c;
	endfunction : make_char

	// ==========================================================
	// State
	// ==========================================================

	fsq_stage_t stage_counter;
	logic wait_period_flag;
	logic slot_match_flag;
	logic parity_error;
	logic carry;
	logic end_stage;
	logic next_slot_match;
	logic [3:0] next_slot;
	logic [3:0] cur;
	fsq_char_t next_instruction_counter [CHARS];
	fsq_char_t instruction_pair_register [CHARS];
	fsq_char_t next_pair [CHARS];
	fsq_char_t static_instruction_register [`FSQ_INSTR_CHARS];
	fsq_char_t sum_char;
	logic [3:0] sum_digit;
	logic sum_carry;
	logic [6:0] chan;

	// ==========================================================
	// Timing source
	// ==========================================================

	// Characters run 12 first, so storage index is position minus one.
	assign cur = 4'(CHARS - 1) - char_index; // RULE_04
	assign minor_end = (char_index == `FSQ_LAST_CHAR);
	assign next_slot = (word_slot_counter == `FSQ_LAST_SLOT) ? 4'h0 : word_slot_counter + 4'h1;

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			char_index <= 4'h0;
		end else if (minor_end) begin
			char_index <= 4'h0;
		end else begin
			char_index <= char_index + 4'h1; // RULE_01
		end
	end

	// One slot count serves all channels, so every channel shows the same slot.
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			word_slot_counter <= 4'h0;
		end else if (minor_end) begin
			word_slot_counter <= next_slot; // RULE_06 RULE_05
		end
	end

	// ==========================================================
	// Stage sequencing
	// ==========================================================

	always_comb begin
		end_stage = 1'b0;
		if (minor_end && !wait_period_flag) begin
			case (stage_counter)
				FSQ_ST_ADDR: end_stage = 1'b1; // RULE_09
				FSQ_ST_FETCH: end_stage = slot_match_flag; // RULE_15
				FSQ_ST_LEFT: end_stage = exec_done; // RULE_20
				FSQ_ST_RIGHT: end_stage = exec_done;
				default: end_stage = 1'b0;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			stage_counter <= FSQ_ST_ADDR; // RULE_23
		end else if (end_stage) begin
			stage_counter <= fsq_stage_t'(stage_counter + 2'b01); // RULE_07 RULE_21
		end
	end

	// A pending parity error keeps the wait flag up, which freezes the machine.
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			wait_period_flag <= 1'b1; // RULE_23
		end else if (end_stage) begin
			wait_period_flag <= 1'b1; // RULE_08 RULE_11
		end else if (minor_end && wait_period_flag && !parity_error) begin
			wait_period_flag <= 1'b0; // RULE_08 RULE_10
		end
	end

	// ==========================================================
	// Memory switch
	// ==========================================================

	assign chan = 7'(digit_val(static_instruction_register[`FSQ_CHAN_DIGIT_HI])) *
		`FSQ_CHAN_WEIGHT + 7'(digit_val(static_instruction_register[`FSQ_CHAN_DIGIT_LO]));

	always_comb begin
		next_slot_match = 1'b0;
		if (stage_counter == FSQ_ST_FETCH) begin
			if (wait_period_flag ? !parity_error : !slot_match_flag) begin
				next_slot_match = (next_slot ==
					digit_val(static_instruction_register[`FSQ_TS_DIGIT])); // RULE_13 RULE_12
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			slot_match_flag <= 1'b0;
		end else if (minor_end) begin
			slot_match_flag <= next_slot_match; // RULE_13
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			mem_chan_sel <= 7'h0;
		end else begin
			mem_chan_sel <= chan; // RULE_14
		end
	end

	// Channel numbers past the last channel open nothing.
	assign mem_out_en = slot_match_flag && (mem_chan_sel < 7'(`FSQ_CHANNELS)); // RULE_14 RULE_03

	// ==========================================================
	// Main bus and parity check
	// ==========================================================

	assign main_bus_valid = (stage_counter == FSQ_ST_ADDR && !wait_period_flag) ||
		slot_match_flag; // RULE_09 RULE_16
	assign main_bus_two = slot_match_flag ? memory_out_bus : next_instruction_counter[cur];

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			parity_error <= 1'b0;
		end else if (main_bus_valid && !(^main_bus_two)) begin
			parity_error <= 1'b1; // RULE_10 RULE_22
		end
	end

	// ==========================================================
	// Instruction pair register
	// ==========================================================

	always_comb begin
		next_pair = instruction_pair_register;
		if (main_bus_valid) begin
			next_pair[cur] = main_bus_two; // RULE_09 RULE_16
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			for (int i = 0; i < CHARS; i++) begin
				instruction_pair_register[i] <= make_char(`FSQ_ZERO_NUMERIC, `FSQ_ZERO_ZONE);
			end
		end else begin
			instruction_pair_register <= next_pair; // RULE_18 RULE_19
		end
	end

	// ==========================================================
	// Static instruction register
	// ==========================================================

	genvar g;
	generate
		for (g = 0; g < `FSQ_INSTR_CHARS; g++) begin : g_static
			always_ff @(posedge ref_clk) begin
				if (!nrst) begin
					static_instruction_register[g] <=
						make_char(`FSQ_ZERO_NUMERIC, `FSQ_ZERO_ZONE);
				end else if (end_stage) begin
					case (stage_counter)
						FSQ_ST_ADDR: static_instruction_register[g] <=
							next_pair[g + `FSQ_RIGHT_BASE]; // RULE_11
						FSQ_ST_FETCH: static_instruction_register[g] <=
							next_pair[g]; // RULE_18
						FSQ_ST_LEFT: static_instruction_register[g] <=
							next_pair[g + `FSQ_RIGHT_BASE]; // RULE_21
						default: static_instruction_register[g] <=
							static_instruction_register[g];
					endcase
				end
			end
			assign decode_table_signals[g*`FSQ_CHAR_BITS +: `FSQ_CHAR_BITS] =
				static_instruction_register[g]; // RULE_20
		end
	endgenerate

	assign instr_execute = (stage_counter == FSQ_ST_LEFT || stage_counter == FSQ_ST_RIGHT) &&
		!wait_period_flag; // RULE_20

	// ==========================================================
	// Next-instruction counter and serial adder
	// ==========================================================

	// Adds one at character 12 and ripples the decimal carry toward character 1.
	always_comb begin
		sum_digit = digit_val(next_instruction_counter[cur]) +
			{3'h0, (char_index == 4'h0) | carry}; // RULE_16
		sum_carry = (sum_digit == `FSQ_DIGIT_TEN);
		if (sum_carry) begin
			sum_digit = 4'h0;
		end
		sum_char = make_char(sum_digit + `FSQ_XS3_BIAS, next_instruction_counter[cur].zone);
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			carry <= 1'b0;
		end else if (slot_match_flag && !minor_end) begin
			carry <= sum_carry;
		end else begin
			carry <= 1'b0;
		end
	end

	// The whole sum lands within the match cycle, so no part is lost at its end.
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			for (int i = 0; i < CHARS; i++) begin
				next_instruction_counter[i] <= make_char(`FSQ_ZERO_NUMERIC, `FSQ_ZERO_ZONE); // RULE_02
			end
		end else if (slot_match_flag) begin
			next_instruction_counter[cur] <= sum_char; // RULE_16 RULE_17
		end
	end

	assign status = '{stage: stage_counter, wait_period_flag: wait_period_flag,
		slot_match_flag: slot_match_flag, parity_error: parity_error,
		halted: parity_error && wait_period_flag};

	// ==========================================================
	// Checks
	// ==========================================================

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	sequence s_wait_twelve;
		wait_period_flag [*8] ##1 wait_period_flag [*4];
	endsequence

	sequence s_wait_ends;
		!wait_period_flag || parity_error;
	endsequence

	property p_wait_one_minor;
		$rose(wait_period_flag) && !parity_error |-> s_wait_twelve ##1 s_wait_ends;
	endproperty
	a_wait_one_minor: assert property (p_wait_one_minor) else $error("wait period length wrong"); // RULE_08

	property p_stage_order;
		stage_counter != $past(stage_counter) |->
			stage_counter == fsq_stage_t'($past(stage_counter) + 2'b01) && wait_period_flag;
	endproperty
	a_stage_order: assert property (p_stage_order) else $error("stage stepped out of order"); // RULE_07

	property p_gate_only_on_match;
		mem_out_en |-> stage_counter == FSQ_ST_FETCH && !wait_period_flag;
	endproperty
	a_gate_only_on_match: assert property (p_gate_only_on_match) else $error("channel opened early"); // RULE_14

	property p_parity_flags;
		main_bus_valid && !(^main_bus_two) |=> parity_error;
	endproperty
	a_parity_flags: assert property (p_parity_flags) else $error("even character not flagged"); // RULE_10

	property p_halt_holds;
		parity_error && wait_period_flag |=> wait_period_flag && $stable(stage_counter);
	endproperty
	a_halt_holds: assert property (p_halt_holds) else $error("machine ran on after error"); // RULE_10

	property p_fetch_bounded;
		disable iff (!nrst || parity_error)
		$rose(stage_counter == FSQ_ST_FETCH) |-> ##[1:132] stage_counter != FSQ_ST_FETCH;
	endproperty
	a_fetch_bounded: assert property (p_fetch_bounded) else $error("fetch stage too long"); // RULE_15

	property p_slot_step;
		minor_end |=> word_slot_counter ==
			(($past(word_slot_counter) == `FSQ_LAST_SLOT) ? 4'h0 : $past(word_slot_counter) + 4'h1);
	endproperty
	a_slot_step: assert property (p_slot_step) else $error("slot counter misstep"); // RULE_06

	property p_address_latched;
		$past(stage_counter) == FSQ_ST_ADDR && stage_counter == FSQ_ST_FETCH |->
			static_instruction_register[`FSQ_TS_DIGIT] == instruction_pair_register[CHARS-1];
	endproperty
	a_address_latched: assert property (p_address_latched) else $error("address not latched"); // RULE_11

	property p_match_is_slot;
		$rose(slot_match_flag) |-> word_slot_counter ==
			digit_val(static_instruction_register[`FSQ_TS_DIGIT]);
	endproperty
	a_match_is_slot: assert property (p_match_is_slot) else $error("match on wrong slot"); // RULE_13

	property p_left_latched;
		$past(stage_counter) == FSQ_ST_FETCH && stage_counter == FSQ_ST_LEFT |->
			static_instruction_register[0] == instruction_pair_register[0];
	endproperty
	a_left_latched: assert property (p_left_latched) else $error("left instruction not latched"); // RULE_18

endmodule : fsq_fetch_sequencer

// ### bench/fsq_mem_model.sv
`timescale 1ns/100ps

// ==========================================================
// Delay-line main storage
module fsq_mem_model (
	input wire logic ref_clk,
	input wire logic mem_out_en,
	input wire logic [6:0] mem_chan_sel,
	input wire logic [3:0] word_slot_counter,
	input wire logic [3:0] char_index,
	input wire logic bad_parity,
	output fsq_pkg::fsq_char_t memory_out_bus
);
	import fsq_pkg::*;
	fsq_char_t last = 7'h00;
	fsq_char_t word_char;
	int digit;
	// All channels show the same slot at once, character 12 leaving first.
	always_comb begin
		digit = (12 - int'(char_index) + int'(word_slot_counter) + int'(mem_chan_sel)) % 10;
		word_char.numeric = 4'(digit) + 4'h3;
		word_char.zone = 2'h0;
		word_char.check = (~^word_char.numeric) ^ (bad_parity && char_index == 4'h0);
	end
	// A closed channel shows a pattern that flips every clock.
	assign memory_out_bus = mem_out_en ? word_char : ~last;
	always_ff @(posedge ref_clk) begin
		last <= memory_out_bus;
	end
endmodule : fsq_mem_model

// ### bench/testbench.sv
`timescale 1ns/100ps

// ==========================================================
// Fetch sequencer regression
module testbench;
	import fsq_pkg::*;
	typedef struct {int exec_minors; int slot; int chan;} fsq_row_t;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic exec_done = 1'b0;
	logic bad_parity = 1'b0;
	fsq_char_t memory_out_bus;
	fsq_char_t main_bus_two;
	logic mem_out_en;
	logic minor_end;
	logic main_bus_valid;
	logic instr_execute;
	logic [6:0] mem_chan_sel;
	logic [3:0] word_slot_counter;
	logic [3:0] char_index;
	logic [41:0] decode_table_signals;
	fsq_status_t status;
	int n_errors = 0;
	int compares = 0;
	int m;
	int s;
	int v;
	int off;
	fsq_row_t row;
	// The counter climbs by one per row, so the last row needs a decimal carry into channel 1.
	fsq_row_t rows[11] = '{'{1, 0, 0}, '{3, 1, 0}, '{2, 2, 0}, '{1, 3, 0}, '{1, 4, 0}, '{1, 5, 0},
		'{1, 6, 0}, '{1, 7, 0}, '{1, 8, 0}, '{2, 9, 0}, '{1, 0, 1}};

	always #4 ref_clk = ~ref_clk;

	fsq_fetch_sequencer i_dut (.ref_clk, .nrst, .memory_out_bus, .exec_done, .mem_out_en,
		.mem_chan_sel, .word_slot_counter, .char_index, .minor_end, .main_bus_two,
		.main_bus_valid, .instr_execute, .decode_table_signals, .status);
	fsq_mem_model i_mem (.ref_clk, .mem_out_en, .mem_chan_sel, .word_slot_counter,
		.char_index, .bad_parity, .memory_out_bus);

	// ==========================================================
	// Helpers
	function automatic fsq_char_t xs3(int d);
		fsq_char_t c;
		c.numeric = 4'(d) + 4'h3;
		c.zone = 2'h0;
		c.check = ~^c.numeric;
		return c;
	endfunction : xs3

	function automatic logic [41:0] mem_half(int first, int slot);
		logic [41:0] r;
		for (int g = 0; g < 6; g++) begin
			r[7*g+:7] = xs3((first + g + slot) % 10);
		end
		return r;
	endfunction : mem_half

	task automatic check(string what, logic [41:0] exp, logic [41:0] got);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic give_verdict();
		$display("Counts: %0d compares, %0d errors", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : give_verdict

	task automatic next_minor();
		int i;
		i = 0;
		do begin
			@(negedge ref_clk);
			i++;
		end while (minor_end !== 1'b1 && i < 13);
		check("minor end", 1'b1, minor_end);
	endtask : next_minor

	// Called at the first clock of a stage; returns at its first clock after the wait.
	task automatic enter(fsq_stage_t st);
		int w;
		w = 0;
		check("stage", st, status.stage);
		while (status.wait_period_flag === 1'b1 && w < 40) begin
			w++;
			@(negedge ref_clk);
		end
		check("wait length", 12, w);
	endtask : enter

	task automatic run_exec(int n, fsq_stage_t nxt);
		repeat (n) next_minor();
		check("executing", 1'b1, instr_execute);
		exec_done = 1'b1;
		@(negedge ref_clk);
		exec_done = 1'b0;
		enter(nxt);
	endtask : run_exec

	task automatic find_match();
		m = 0;
		while (mem_out_en !== 1'b1 && m < 12) begin
			next_minor();
			@(negedge ref_clk);
			m++;
		end
	endtask : find_match

	task automatic check_reset();
		check("reset stage", FSQ_ST_ADDR, status.stage);
		check("reset wait", 1'b1, status.wait_period_flag);
		check("reset error", 1'b0, status.parity_error);
		check("reset slot", 4'h0, word_slot_counter);
		check("reset char", 4'h0, char_index);
		check("reset static", {6{xs3(0)}}, decode_table_signals);
	endtask : check_reset

	// ==========================================================
	// Main sequence
	initial begin
		repeat (16) @(negedge ref_clk);
		check_reset();
		nrst = 1'b1;
		enter(FSQ_ST_ADDR);
		$display("reset test done");
		for (int k = 0; k < 11; k++) begin
			row = rows[k];
			v = row.chan * 10 + row.slot;
			off = row.slot + row.chan;
			for (int c = 0; c < 12; c++) begin
				check("bus valid", 1'b1, main_bus_valid);
				check("char index", c, char_index);
				check("counter char", xs3(v % 10), main_bus_two);
				v = v / 10;
				if (c < 11) @(negedge ref_clk);
			end
			@(negedge ref_clk);
			enter(FSQ_ST_FETCH);
			check("addr half", {xs3(row.slot), xs3(row.chan)}, decode_table_signals[41:28]);
			check("addr low", {4{xs3(0)}}, decode_table_signals[27:0]);
			s = int'(word_slot_counter);
			find_match();
			check("match delay", (row.slot - s + 10) % 10, m);
			for (int c = 0; c < 12; c++) begin
				check("match flag", 1'b1, status.slot_match_flag);
				check("channel", 7'(row.chan), mem_chan_sel);
				check("slot", row.slot, word_slot_counter);
				check("mem char", xs3((12 - c + off) % 10), main_bus_two);
				@(negedge ref_clk);
			end
			enter(FSQ_ST_LEFT);
			check("channel closed", 1'b0, mem_out_en);
			check("left half", mem_half(1, off), decode_table_signals);
			run_exec(row.exec_minors, FSQ_ST_RIGHT);
			check("right half", mem_half(7, off), decode_table_signals);
			run_exec(1, FSQ_ST_ADDR);
			check("no error", 1'b0, status.parity_error);
			$display("fetch row %0d done", k);
		end
		// A flipped check bit in the fetched word stops the machine at the next wait.
		bad_parity = 1'b1;
		next_minor();
		@(negedge ref_clk);
		enter(FSQ_ST_FETCH);
		find_match();
		next_minor();
		bad_parity = 1'b0;
		repeat (37) @(negedge ref_clk);
		check("halt stage", FSQ_ST_LEFT, status.stage);
		check("halt wait", 1'b1, status.wait_period_flag);
		check("halted", 1'b1, status.halted);
		check("halt exec", 1'b0, instr_execute);
		$display("parity halt test done");
		nrst = 1'b0;
		repeat (2) @(negedge ref_clk);
		check_reset();
		nrst = 1'b1;
		enter(FSQ_ST_ADDR);
		check("counter zero", xs3(0), main_bus_two);
		$display("second reset test done");
		give_verdict();
	end

	initial begin
		repeat (20000) @(posedge ref_clk);
		n_errors++;
		$display("[ERR] watchdog expected finish seen timeout");
		give_verdict();
	end
endmodule : testbench
